// ==== inc/ca_cfg_pkg.sv ====
// Constants shared by the counter array mode and cycle configuration logic
package ca_cfg_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] MODE_ADDR = 8'hd9;
    localparam logic [7:0] PWMCFG_ADDR = 8'hdf;
    // Mode register fields
    localparam int MD_IDLE_BIT = 7;
    localparam int MD_WATCHDOG_ENABLE_BIT_BIT = 6;
    localparam int MD_WATCHDOG_LOCK_BIT_BIT = 5;
    localparam int MD_TB_LSB = 1;
    localparam int MD_ECF_BIT = 0;
    // Cycle configuration register fields
    localparam int PW_RELOAD_BANK_SELECT_BIT = 7;
    localparam int PW_CYCLE_WRAP_IRQ_ENABLE_BIT = 6;
    localparam int PW_CYCLE_WRAP_FLAG_BIT = 5;
    localparam int PW_CLSEL_LSB = 0;
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] PWMCFG_RESET = 8'h00;
    // Timebase codes
    typedef enum logic [2:0] {
        TB_SYS_DIV12 = 3'b000,
        TB_SYS_DIV4 = 3'b001,
        TB_TIMER0 = 3'b010,
        TB_EXT_EDGE = 3'b011,
        TB_SYS = 3'b100,
        TB_EXT_DIV8 = 3'b101,
        TB_RSVD6 = 3'b110,
        TB_RSVD7 = 3'b111
    } timebase_t;
    // Divider, counter, channel and width figures
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam int CHANNELS = 6;
    localparam logic [4:0] PWM16_BITS = 5'h10;
endpackage

// ==== verilog/ca_timebase.sv ====
// Counter increment source selection and prescalers
`timescale 1ns/100ps
module ca_timebase import ca_cfg_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Source selection
    input wire logic [2:0] timebase_select,
    // Raw sources
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    // Increment request
    output logic tick_r
);
    logic [3:0] div12_r;
    logic [1:0] div4_r;
    logic [2:0] div8_r;
    logic eci_prev_r;
    logic ext_prev_r;
    logic div8_tick;
    logic tick_nxt;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div12_r <= 4'h0;
            div4_r <= 2'h0;
        end else begin
            div12_r <= (div12_r == DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
            div4_r <= div4_r + 2'h1;
        end
    end

    // Edge detectors on synchronous pin inputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eci_prev_r <= 1'b1;
            ext_prev_r <= 1'b0;
            div8_r <= 3'h0;
        end else begin
            eci_prev_r <= external_count_input;
            ext_prev_r <= external_clock;
            if (external_clock && !ext_prev_r) begin
                div8_r <= div8_r + 3'h1;
            end
        end
    end

    assign div8_tick = external_clock && !ext_prev_r && (div8_r == DIV8_LAST);

    always_comb begin
        unique case (timebase_t'(timebase_select))
            TB_SYS_DIV12: tick_nxt = (div12_r == DIV12_LAST);
            TB_SYS_DIV4: tick_nxt = (div4_r == DIV4_LAST);
            TB_TIMER0: tick_nxt = timer0_overflow;
            TB_EXT_EDGE: tick_nxt = eci_prev_r && !external_count_input;
            TB_SYS: tick_nxt = 1'b1;
            TB_EXT_DIV8: tick_nxt = div8_tick;
            TB_RSVD6: tick_nxt = 1'b0;
            TB_RSVD7: tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
        end
    end
endmodule // ca_timebase

// ==== verilog/ca_main_counter.sv ====
// Main 16-bit array counter with full and cycle wrap detection
`timescale 1ns/100ps
module ca_main_counter import ca_cfg_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic advance,
    input wire logic [4:0] cycle_bits,
    // State
    output logic [15:0] count_r,
    output logic full_wrap_r,
    output logic cycle_wrap_r
);
    logic [15:0] low_mask;

    // Ones in the low cycle_bits positions
    assign low_mask = ~(16'hffff << cycle_bits);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_r <= 16'h0000;
            full_wrap_r <= 1'b0;
            cycle_wrap_r <= 1'b0;
        end else begin
            full_wrap_r <= 1'b0;
            cycle_wrap_r <= 1'b0;
            if (advance) begin
                count_r <= count_r + 16'h0001;
                full_wrap_r <= (count_r == COUNT_MAX);
                cycle_wrap_r <= ((count_r & low_mask) == low_mask);
            end
        end
    end
endmodule // ca_main_counter

// ==== verilog/ca_mode_cfg.sv ====
// Counter array mode and PWM cycle configuration registers
`timescale 1ns/100ps

// How it works
// - Idle-suspend bit halts array during CPU idle
// - Watchdog enable dedicates one module to watchdog
// - Lock keeps watchdog enabled until reset
// - Watchdog running freezes other mode bits
// - Mode bit 4 reads zero, writes ignored
// - Timebase select picks counter increment source
// - External edge mode counts falling input edges
// - External clock divided by eight, synchronized
// - Overflow enable gates counter overflow interrupt
// - Bank select steers compare accesses to reload
// - Reload values used only in 9-11 bit PWM
// - Cycle wrap enable gates cycle wrap interrupt
// - Cycle wrap flag from chosen counter bit
// - Cycle flag set by hardware or software only
// - Cycle register bits 4:2 read zero
// - Cycle select gives 8, 9, 10, 11 bits
// - 16-bit PWM channels ignore cycle select
// - Overflow flag set on 16-bit counter wrap
// - Watchdog enable resets to one
module ca_mode_cfg import ca_cfg_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_r,
    // System state
    input wire logic cpu_idle,
    input wire logic counter_run,
    input wire logic overflow_flag_clear,
    // Increment sources
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    // Per-channel PWM configuration
    input wire logic [CHANNELS-1:0] channel_pwm_en,
    input wire logic [CHANNELS-1:0] channel_pwm16,
    // Status and control outputs
    output logic irq_req_r,
    output logic counter_overflow_flag_r,
    output logic watchdog_module_dedicated_r,
    output logic reload_bank_r,
    output logic [CHANNELS-1:0] channel_reload_use_r,
    output logic [CHANNELS*5-1:0] channel_cycle_bits_r,
    output logic [15:0] main_array_counter_r,
    output logic full_wrap_r,
    output logic cycle_wrap_r
);
    // Mode register fields
    logic idle_suspend_r;
    logic watchdog_enable_bit_r;
    logic watchdog_lock_bit_r;
    logic [2:0] timebase_select_r;
    logic overflow_irq_enable_r;
    // Cycle configuration fields
    logic reload_bank_select_r;
    logic cycle_wrap_irq_enable_r;
    logic cycle_wrap_flag_r;
    logic [1:0] cycle_length_select_r;

    logic mode_wr;
    logic pwm_wr;
    logic tick;
    logic advance;
    logic [4:0] cycle_bits;
    logic [15:0] count;
    logic full_wrap;
    logic cycle_wrap;
    logic [7:0] rdata_nxt;

    // Cycle length in bits for a select code
    function automatic logic [4:0] cycle_len(input logic [1:0] sel);
        unique case (sel)
            2'b00: cycle_len = 5'h08;
            2'b01: cycle_len = 5'h09;
            2'b10: cycle_len = 5'h0a;
            2'b11: cycle_len = 5'h0b;
        endcase
    endfunction

    assign mode_wr = sfr_wr && (sfr_addr == MODE_ADDR);
    assign pwm_wr = sfr_wr && (sfr_addr == PWMCFG_ADDR);
    assign cycle_bits = cycle_len(cycle_length_select_r);

    // Watchdog forces the counter on; idle suspend still wins
    assign advance = tick && (counter_run || watchdog_enable_bit_r)
                     && !(cpu_idle && idle_suspend_r);

    ca_timebase u_timebase (
        .clk(clk),
        .sys_rst(sys_rst),
        .timebase_select(timebase_select_r),
        .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input),
        .external_clock(external_clock),
        .tick_r(tick)
    );

    ca_main_counter u_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .advance(advance),
        .cycle_bits(cycle_bits),
        .count_r(count),
        .full_wrap_r(full_wrap),
        .cycle_wrap_r(cycle_wrap)
    );

    // Watchdog enable and lock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdog_enable_bit_r <= MODE_RESET[MD_WATCHDOG_ENABLE_BIT_BIT];
            watchdog_lock_bit_r <= MODE_RESET[MD_WATCHDOG_LOCK_BIT_BIT];
        end else if (mode_wr) begin
            // Setting the lock also enables; lock only clears at reset
            if (sfr_wdata[MD_WATCHDOG_LOCK_BIT_BIT]) begin
                watchdog_lock_bit_r <= 1'b1;
                watchdog_enable_bit_r <= 1'b1;
            end else if (!watchdog_lock_bit_r) begin
                watchdog_enable_bit_r <= sfr_wdata[MD_WATCHDOG_ENABLE_BIT_BIT];
            end
        end
    end

    // Remaining mode bits, frozen while the watchdog runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_suspend_r <= MODE_RESET[MD_IDLE_BIT];
            timebase_select_r <= MODE_RESET[MD_TB_LSB +: 3];
            overflow_irq_enable_r <= MODE_RESET[MD_ECF_BIT];
        end else if (mode_wr && !watchdog_enable_bit_r) begin
            idle_suspend_r <= sfr_wdata[MD_IDLE_BIT];
            timebase_select_r <= sfr_wdata[MD_TB_LSB +: 3];
            overflow_irq_enable_r <= sfr_wdata[MD_ECF_BIT];
        end
    end

    // Cycle configuration control bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reload_bank_select_r <= PWMCFG_RESET[PW_RELOAD_BANK_SELECT_BIT];
            cycle_wrap_irq_enable_r <= PWMCFG_RESET[PW_CYCLE_WRAP_IRQ_ENABLE_BIT];
            cycle_length_select_r <= PWMCFG_RESET[PW_CLSEL_LSB +: 2];
        end else if (pwm_wr) begin
            reload_bank_select_r <= sfr_wdata[PW_RELOAD_BANK_SELECT_BIT];
            cycle_wrap_irq_enable_r <= sfr_wdata[PW_CYCLE_WRAP_IRQ_ENABLE_BIT];
            cycle_length_select_r <= sfr_wdata[PW_CLSEL_LSB +: 2];
        end
    end

    // Cycle wrap flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cycle_wrap_flag_r <= PWMCFG_RESET[PW_CYCLE_WRAP_FLAG_BIT];
        end else if (cycle_wrap) begin
            cycle_wrap_flag_r <= 1'b1;
        end else if (pwm_wr) begin
            cycle_wrap_flag_r <= sfr_wdata[PW_CYCLE_WRAP_FLAG_BIT];
        end
    end

    // Counter overflow flag, cleared only by software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter_overflow_flag_r <= 1'b0;
        end else if (full_wrap) begin
            counter_overflow_flag_r <= 1'b1;
        end else if (overflow_flag_clear) begin
            counter_overflow_flag_r <= 1'b0;
        end
    end

    // One shared interrupt request line
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_req_r <= 1'b0;
        end else begin
            irq_req_r <= (counter_overflow_flag_r && overflow_irq_enable_r)
                || (cycle_wrap_flag_r && cycle_wrap_irq_enable_r);
        end
    end

    // Status mirrored to outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdog_module_dedicated_r <= MODE_RESET[MD_WATCHDOG_ENABLE_BIT_BIT];
            reload_bank_r <= PWMCFG_RESET[PW_RELOAD_BANK_SELECT_BIT];
            main_array_counter_r <= 16'h0000;
            full_wrap_r <= 1'b0;
            cycle_wrap_r <= 1'b0;
        end else begin
            watchdog_module_dedicated_r <= watchdog_enable_bit_r;
            reload_bank_r <= reload_bank_select_r;
            main_array_counter_r <= count;
            full_wrap_r <= full_wrap;
            cycle_wrap_r <= cycle_wrap;
        end
    end

    // Per-channel reload use and effective cycle length
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    channel_reload_use_r[ch] <= 1'b0;
                    channel_cycle_bits_r[ch*5 +: 5] <= 5'h08;
                end else begin
                    // Reload only for 9 to 11 bit cycles
                    channel_reload_use_r[ch] <= channel_pwm_en[ch]
                        && !channel_pwm16[ch]
                        && (cycle_length_select_r != 2'b00);
                    channel_cycle_bits_r[ch*5 +: 5] <= channel_pwm16[ch]
                        ? PWM16_BITS : cycle_bits;
                end
            end
        end
    endgenerate

    // Read data; unmapped addresses return zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_addr == MODE_ADDR) begin
            rdata_nxt[MD_IDLE_BIT] = idle_suspend_r;
            rdata_nxt[MD_WATCHDOG_ENABLE_BIT_BIT] = watchdog_enable_bit_r;
            rdata_nxt[MD_WATCHDOG_LOCK_BIT_BIT] = watchdog_lock_bit_r;
            rdata_nxt[MD_TB_LSB +: 3] = timebase_select_r;
            rdata_nxt[MD_ECF_BIT] = overflow_irq_enable_r;
        end else if (sfr_addr == PWMCFG_ADDR) begin
            rdata_nxt[PW_RELOAD_BANK_SELECT_BIT] = reload_bank_select_r;
            rdata_nxt[PW_CYCLE_WRAP_IRQ_ENABLE_BIT] = cycle_wrap_irq_enable_r;
            rdata_nxt[PW_CYCLE_WRAP_FLAG_BIT] = cycle_wrap_flag_r;
            rdata_nxt[PW_CLSEL_LSB +: 2] = cycle_length_select_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sfr_rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_r <= rdata_nxt;
        end
    end
endmodule // ca_mode_cfg

// ==== test/ext_source.sv ====
// Far-side source model: timer 0 overflow pulses and external count pins
`timescale 1ns/100ps
module ext_source (
    // Clock and control
    input wire logic clk,
    input wire logic active,
    input wire logic slow,
    // Source pins
    output logic timer0_overflow,
    output logic external_count_input,
    output logic external_clock
);
    logic [2:0] ph_r = 3'h0;
    initial begin
        timer0_overflow = 1'b0;
        external_count_input = 1'b1;
        external_clock = 1'b0;
    end
    // Pins stand still outside a frame; fastest edge rate is a quarter of clk
    always @(posedge clk) begin
        if (active) begin
            ph_r <= ph_r + 3'h1;
            timer0_overflow <= slow ? ph_r == 3'h7 : ph_r[1:0] == 2'h3;
            external_count_input <= slow ? ph_r[2] : ph_r[1];
            external_clock <= slow ? ph_r[2] : ph_r[1];
        end else begin
            timer0_overflow <= 1'b0;
        end
    end
endmodule // ext_source

// ==== test/ca_mode_cfg_monitor.sv ====
// Port-level assertions for the mode and cycle configuration block
`timescale 1ns/100ps
module ca_mode_cfg_monitor import ca_cfg_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_r,
    // Status
    input wire logic overflow_flag_clear,
    input wire logic [CHANNELS-1:0] channel_pwm_en,
    input wire logic [CHANNELS-1:0] channel_pwm16,
    input wire logic counter_overflow_flag_r,
    input wire logic watchdog_module_dedicated_r,
    input wire logic reload_bank_r,
    input wire logic [CHANNELS-1:0] channel_reload_use_r,
    input wire logic [CHANNELS*5-1:0] channel_cycle_bits_r,
    input wire logic full_wrap_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rd_mode_q;
    logic lock_seen_r;
    // Once lock is seen on a read, the watchdog must stay dedicated until the next reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_mode_q <= 1'b0;
            lock_seen_r <= 1'b0;
        end else begin
            rd_mode_q <= sfr_rd && sfr_addr == MODE_ADDR;
            if (rd_mode_q && sfr_rdata_r[MD_WATCHDOG_LOCK_BIT_BIT]) lock_seen_r <= 1'b1;
        end
    end
    property p_wd_reset; $past(sys_rst) |-> watchdog_module_dedicated_r; endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog off after reset");
    // Flag and the wrap pulse are launched on the same edge
    property p_flag_rise; $rose(counter_overflow_flag_r) |-> full_wrap_r; endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag without wrap");
    property p_flag_hold;
        counter_overflow_flag_r && !overflow_flag_clear |=> counter_overflow_flag_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");
    property p_mode_unused; sfr_rd && sfr_addr == MODE_ADDR |=> !sfr_rdata_r[4]; endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("mode bit 4 not zero");
    property p_pw_unused;
        sfr_rd && sfr_addr == PWMCFG_ADDR |=> sfr_rdata_r[4:2] == 3'b000;
    endproperty
    a_pw_unused: assert property (p_pw_unused) else $error("cycle cfg 4:2 not zero");
    property p_lock; lock_seen_r |-> watchdog_module_dedicated_r; endproperty
    a_lock: assert property (p_lock) else $error("locked watchdog turned off");
    property p_bank;
        sfr_rd && !sfr_wr && sfr_addr == PWMCFG_ADDR |=>
            sfr_rdata_r[PW_RELOAD_BANK_SELECT_BIT] == reload_bank_r;
    endproperty
    a_bank: assert property (p_bank) else $error("bank select mismatch");
    property p_pwm16;
        (channel_pwm_en[1] && channel_pwm16[1]) [*2] |->
            channel_cycle_bits_r[9:5] == PWM16_BITS && !channel_reload_use_r[1];
    endproperty
    a_pwm16: assert property (p_pwm16) else $error("16-bit channel follows select");
    c_wrap: cover property (full_wrap_r);
    c_lock: cover property (lock_seen_r);
    c_pw_read: cover property (sfr_rd && sfr_addr == PWMCFG_ADDR);
endmodule // ca_mode_cfg_monitor

bind ca_mode_cfg ca_mode_cfg_monitor mon (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_rdata_r, .overflow_flag_clear, .channel_pwm_en, .channel_pwm16,
    .counter_overflow_flag_r, .watchdog_module_dedicated_r, .reload_bank_r,
    .channel_reload_use_r, .channel_cycle_bits_r, .full_wrap_r);

// ==== test/testbench.sv ====
// Self-checking bench for the counter array mode and cycle configuration
`timescale 1ns/100ps
module testbench import ca_cfg_pkg::*; ;
    logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, cpu_idle = 1'b0;
    logic counter_run = 1'b1, overflow_flag_clear = 1'b0, active = 1'b0, slow = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_r;
    logic [CHANNELS-1:0] channel_pwm_en = 6'h03, channel_pwm16 = 6'h02, channel_reload_use_r;
    logic irq_req_r, counter_overflow_flag_r, watchdog_module_dedicated_r, reload_bank_r;
    logic full_wrap_r, cycle_wrap_r, timer0_overflow, external_count_input, external_clock;
    logic [CHANNELS*5-1:0] channel_cycle_bits_r;
    logic [15:0] main_array_counter_r;
    logic [15:0] rnd = 16'h12b7; // Seed 4791
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    int tb_exp[9] = '{20, 60, 60, 60, 240, 7, 0, 0, 30};

    ca_mode_cfg dut (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_r,
        .cpu_idle, .counter_run, .overflow_flag_clear, .timer0_overflow,
        .external_count_input, .external_clock, .channel_pwm_en, .channel_pwm16, .irq_req_r,
        .counter_overflow_flag_r, .watchdog_module_dedicated_r, .reload_bank_r,
        .channel_reload_use_r, .channel_cycle_bits_r, .main_array_counter_r, .full_wrap_r,
        .cycle_wrap_r);
    ext_source src (.clk, .active, .slow, .timer0_overflow, .external_count_input,
        .external_clock);

    always #10 clk = ~clk;

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    // Expected read data waits in the queue for the watcher
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
    endtask
    task automatic await(ref logic s, input int lim, output int k);
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        check(16'(k < lim), 16'h0001);
    endtask

    always @(posedge clk) begin
        rd_d <= sfr_rd;
        if (rd_d) check(16'(sfr_rdata_r), 16'(exp_q.pop_front()));
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        int i, n;
        logic [15:0] c0;
        logic [2:0] code;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(MODE_ADDR, MODE_RESET);
        rd(PWMCFG_ADDR, PWMCFG_RESET);
        rnd = nxt(rnd);
        rd(rnd[7:0] == MODE_ADDR || rnd[7:0] == PWMCFG_ADDR ? 8'h00 : rnd[7:0], 8'h00);
        // Running watchdog freezes the other bits; clearing it still works
        wr(MODE_ADDR, 8'h8f);
        rd(MODE_ADDR, 8'h00);
        check(16'(watchdog_module_dedicated_r), 16'h0000);
        wr(MODE_ADDR, 8'h9f);
        rd(MODE_ADDR, 8'h8f);
        $display("test register access done");
        for (i = 0; i < 9; i++) begin
            code = (i == 8) ? 3'h3 : i[2:0];
            wr(MODE_ADDR, {4'h0, code, 1'b0});
            slow <= (i == 8);
            active <= 1'b1;
            repeat (4) @(posedge clk);
            c0 = main_array_counter_r;
            repeat (240) @(posedge clk);
            n = int'(main_array_counter_r - c0);
            check(16'(n >= tb_exp[i] - 1 && n <= tb_exp[i] + 1), 16'h0001);
            active <= 1'b0;
        end
        $display("test timebase done");
        wr(MODE_ADDR, 8'h88);
        cpu_idle <= 1'b1;
        repeat (4) @(posedge clk);
        c0 = main_array_counter_r;
        repeat (20) @(posedge clk);
        check(main_array_counter_r - c0, 16'h0000);
        wr(MODE_ADDR, 8'h08);
        repeat (4) @(posedge clk);
        c0 = main_array_counter_r;
        repeat (20) @(posedge clk);
        check(main_array_counter_r - c0, 16'h0014);
        cpu_idle <= 1'b0;
        // Watchdog off: run control alone decides
        counter_run <= 1'b0;
        repeat (4) @(posedge clk);
        c0 = main_array_counter_r;
        repeat (20) @(posedge clk);
        check(main_array_counter_r - c0, 16'h0000);
        counter_run <= 1'b1;
        $display("test idle done");
        for (i = 0; i < 4; i++) begin
            wr(PWMCFG_ADDR, {6'h00, i[1:0]});
            repeat (3) @(posedge clk);
            check(16'(channel_cycle_bits_r[4:0]), 16'(8 + i));
            check(16'(channel_reload_use_r[1:0]), 16'(i != 0));
            check(16'(channel_cycle_bits_r[9:5]), 16'(PWM16_BITS));
            await(cycle_wrap_r, 3000, n);
            @(posedge clk);
            await(cycle_wrap_r, 3000, n);
            check(16'(n + 1), 16'(1 << (8 + i)));
        end
        wr(PWMCFG_ADDR, 8'h40);
        await(cycle_wrap_r, 3000, n);
        repeat (3) @(posedge clk);
        check(16'(irq_req_r), 16'h0001);
        rd(PWMCFG_ADDR, 8'h60);
        wr(PWMCFG_ADDR, 8'h00);
        repeat (3) @(posedge clk);
        check(16'(irq_req_r), 16'h0000);
        rnd = nxt(rnd);
        wr(PWMCFG_ADDR, rnd[7:0] | 8'h20);
        rd(PWMCFG_ADDR, (rnd[7:0] & 8'he3) | 8'h20);
        check(16'(reload_bank_r), 16'(rnd[7]));
        wr(PWMCFG_ADDR, 8'h00);
        $display("test cycle length done");
        wr(MODE_ADDR, 8'h09);
        await(full_wrap_r, 70000, n);
        repeat (3) @(posedge clk);
        check(16'(counter_overflow_flag_r), 16'h0001);
        check(16'(irq_req_r), 16'h0001);
        wr(MODE_ADDR, 8'h08);
        repeat (2) @(posedge clk);
        check(16'(irq_req_r), 16'h0000);
        overflow_flag_clear <= 1'b1;
        @(posedge clk);
        overflow_flag_clear <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(counter_overflow_flag_r), 16'h0000);
        $display("test overflow done");
        wr(MODE_ADDR, 8'h20);
        rd(MODE_ADDR, 8'h60);
        check(16'(watchdog_module_dedicated_r), 16'h0001);
        // Watchdog keeps the divide-by-12 count going with run control off
        counter_run <= 1'b0;
        repeat (4) @(posedge clk);
        c0 = main_array_counter_r;
        repeat (24) @(posedge clk);
        check(main_array_counter_r - c0, 16'h0002);
        wr(MODE_ADDR, 8'h00);
        rd(MODE_ADDR, 8'h60);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(MODE_ADDR, MODE_RESET);
        repeat (3) @(posedge clk);
        $display("test lock done");
        conclude();
    end
endmodule // testbench
